// *** hdl/irv_remap.sv ***
// Purpose: Interrupt latch, maskable interrupt request and vector remap
// Assumes: Processor address and valid strobe are on clock_i
// Notes: Remapped address is registered, one cycle behind the input
// Behaviour
// RULE1: After power on, drive an active-low reset pulse to the system and processor.
// RULE2: On reset release the processor fetches its start vector at FFFE and FFFF.
// RULE3: Panel or board switch NMI makes the processor fetch FFFC and FFFD.
// RULE4: Show which source raised NMI as MSB of the adapter's port A.
// RULE5: Software interrupt instruction makes the processor fetch FFFA and FFFB.
// RULE6: Latch eight request inputs onto level lines zero to seven.
// RULE7: Raise maskable interrupt when any unmasked latched level line is active.
// RULE8: Processor acknowledges maskable interrupt by reading FFF8 and FFF9.
// RULE9: Replace FFF8/FFF9 with a pair in the table at FFE8 chosen by level.
// RULE10: In boot-load phase the pair addresses the table at 01E8-01F7 instead.
// RULE11: Highest active unmasked level wins; pair at twice the level in table.
// RULE12: Requests stay until withdrawn; only vector fetch addresses are remapped.
`timescale 1ns/1ns
`default_nettype none
`include "irv_params.svh"
module irv_remap (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Interrupt request pins, level 0 to 7
	input wire logic [7:0] irq_req_i,
	// Level mask, high suppresses a level
	input wire logic [7:0] irq_mask_i,
	// NMI sources
	input wire irv_pkg::irv_nmi_src_t nmi_src_i,
	// Boot-load phase
	input wire logic boot_load_phase_i,
	// Processor address bus
	input wire irv_pkg::irv_cpu_bus_t cpu_bus_i,
	// Remapped address bus
	output irv_pkg::irv_cpu_bus_t mem_bus_o,
	// Processor interrupt and reset lines
	output logic irq_b_o,
	output logic nmi_b_o,
	output logic sys_reset_b_o,
	// Status to parallel interface adapter
	output logic [7:0] irq_level_lines_o,
	output logic nmi_source_o
);
	localparam int POR_W = $clog2(`IRV_POR_CYCLES + 1);
	localparam logic [POR_W-1:0] POR_LAST = POR_W'(`IRV_POR_CYCLES);

	logic rst_s1_r;
	logic rst_s2_r;
	logic rst_s1_nxt;
	logic rst_s2_nxt;
	logic rst_b;

	logic [7:0] req_sync;
	logic [1:0] nmi_sync;

	logic [7:0] lvl_r;
	logic [7:0] lvl_nxt;
	logic nmi_src_r;
	logic nmi_src_nxt;
	logic [POR_W-1:0] por_cnt_r;
	logic [POR_W-1:0] por_cnt_nxt;
	logic por_b_r;
	logic por_b_nxt;
	logic irq_b_r;
	logic irq_b_nxt;
	logic nmi_b_r;
	logic nmi_b_nxt;

	irv_pkg::irv_state_t state_r;
	irv_pkg::irv_state_t state_nxt;
	logic [2:0] held_lvl_r;
	logic [2:0] held_lvl_nxt;
	irv_pkg::irv_cpu_bus_t bus_r;
	irv_pkg::irv_cpu_bus_t bus_nxt;

	logic [7:0] active;
	logic [2:0] top_lvl;

	// Table address for a level and low/high byte of the pair
	function automatic logic [15:0] irv_vec_addr(input logic boot, input logic [2:0] lvl,
		input logic lo);
		logic [15:0] base;
		base = boot ? `IRV_RWM_TABLE : `IRV_ROM_TABLE;
		irv_vec_addr = base + {12'h000, lvl, lo};
	endfunction

	// Reset release through two flip-flops
	always_comb begin
		rst_s1_nxt = 1'b1;
		rst_s2_nxt = rst_s1_r;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= rst_s1_nxt;
			rst_s2_r <= rst_s2_nxt;
		end
	end
	assign rst_b = rst_s2_r;

	irv_sync3 #(.W(8)) u_req_sync (
		.clock_i(clock_i),
		.rst_b_i(rst_b),
		.d_i(irq_req_i),
		.q_o(req_sync)
	);

	irv_sync3 #(.W(2)) u_nmi_sync (
		.clock_i(clock_i),
		.rst_b_i(rst_b),
		.d_i({nmi_src_i.panel, ~nmi_src_i.switch_n}),
		.q_o(nmi_sync)
	);

	// Highest unmasked active level
	always_comb begin
		active = lvl_r & ~irq_mask_i;
		top_lvl = 3'h0;
		for (int i = 0; i < `IRV_LEVELS; i++) begin
			if (active[i]) begin
				top_lvl = 3'(i); // RULE11
			end
		end
	end

	// Latch and interrupt lines
	always_comb begin
		lvl_nxt = req_sync; // RULE6 RULE12
		irq_b_nxt = ~(|active); // RULE7
		nmi_b_nxt = ~(|nmi_sync);
		nmi_src_nxt = nmi_src_r;
		if (nmi_sync[1]) begin
			nmi_src_nxt = 1'b1; // RULE4
		end else if (nmi_sync[0]) begin
			nmi_src_nxt = 1'b0; // RULE4
		end
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			lvl_r <= 8'h00;
			irq_b_r <= 1'b1;
			nmi_b_r <= 1'b1;
			nmi_src_r <= 1'b0;
		end else begin
			lvl_r <= lvl_nxt;
			irq_b_r <= irq_b_nxt;
			nmi_b_r <= nmi_b_nxt;
			nmi_src_r <= nmi_src_nxt;
		end
	end

	// Power-on pulse to the system and processor
	always_comb begin
		por_cnt_nxt = por_cnt_r;
		por_b_nxt = por_b_r;
		if (por_cnt_r != POR_LAST) begin
			por_cnt_nxt = por_cnt_r + POR_W'(1);
		end else begin
			por_b_nxt = 1'b1; // RULE1
		end
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			por_cnt_r <= '0;
			por_b_r <= 1'b0;
		end else begin
			por_cnt_r <= por_cnt_nxt;
			por_b_r <= por_b_nxt;
		end
	end

	// Vector fetch remap; level frozen between the two bytes
	always_comb begin
		state_nxt = state_r;
		held_lvl_nxt = held_lvl_r;
		bus_nxt = cpu_bus_i; // RULE12
		case (state_r)
			irv_pkg::IRV_IDLE: begin
				if (cpu_bus_i.valid && cpu_bus_i.addr == `IRV_VEC_IRQ_HI) begin // RULE8
					held_lvl_nxt = top_lvl;
					bus_nxt.addr = irv_vec_addr(boot_load_phase_i, top_lvl, 1'b0); // RULE9 RULE10
					state_nxt = irv_pkg::IRV_HOLD;
				end else if (cpu_bus_i.valid && cpu_bus_i.addr == `IRV_VEC_IRQ_LO) begin
					bus_nxt.addr = irv_vec_addr(boot_load_phase_i, top_lvl, 1'b1); // RULE9 RULE10
				end
			end
			irv_pkg::IRV_HOLD: begin
				if (cpu_bus_i.valid && cpu_bus_i.addr == `IRV_VEC_IRQ_LO) begin
					bus_nxt.addr = irv_vec_addr(boot_load_phase_i, held_lvl_r, 1'b1); // RULE9 RULE10
					state_nxt = irv_pkg::IRV_IDLE;
				end else if (cpu_bus_i.valid && cpu_bus_i.addr == `IRV_VEC_IRQ_HI) begin
					held_lvl_nxt = top_lvl;
					bus_nxt.addr = irv_vec_addr(boot_load_phase_i, top_lvl, 1'b0); // RULE9 RULE10
				end else if (cpu_bus_i.valid) begin
					state_nxt = irv_pkg::IRV_IDLE;
				end
			end
			default: begin
				state_nxt = irv_pkg::IRV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= irv_pkg::IRV_IDLE;
			held_lvl_r <= 3'h0;
			bus_r <= '0;
		end else begin
			state_r <= state_nxt;
			held_lvl_r <= held_lvl_nxt;
			bus_r <= bus_nxt;
		end
	end

	assign mem_bus_o = bus_r;
	assign irq_b_o = irq_b_r;
	assign nmi_b_o = nmi_b_r;
	assign sys_reset_b_o = por_b_r;
	assign irq_level_lines_o = lvl_r;
	assign nmi_source_o = nmi_src_r;
endmodule
`default_nettype wire

// *** hdl/irv_params.svh ***
// Purpose: Constants for the interrupt vector remapper
// Assumes: 50 MHz clock, 16-bit processor address bus
// Notes: Vector addresses are byte addresses of the processor
`ifndef IRV_PARAMS_SVH
`define IRV_PARAMS_SVH

`define IRV_CLK_MHZ 50
`define IRV_POR_TIME_NS 2000
`define IRV_POR_CYCLES ((`IRV_POR_TIME_NS * `IRV_CLK_MHZ + 999) / 1000)
`define IRV_LEVELS 8
`define IRV_VEC_RESET_HI 16'hFFFE
`define IRV_VEC_RESET_LO 16'hFFFF
`define IRV_VEC_NMI_HI 16'hFFFC
`define IRV_VEC_NMI_LO 16'hFFFD
`define IRV_VEC_SWI_HI 16'hFFFA
`define IRV_VEC_SWI_LO 16'hFFFB
`define IRV_VEC_IRQ_HI 16'hFFF8
`define IRV_VEC_IRQ_LO 16'hFFF9
`define IRV_ROM_TABLE 16'hFFE8
`define IRV_RWM_TABLE 16'h01E8
`define IRV_LVL_SOFT 3'h0
`define IRV_LVL_TIMER 3'h1
`define IRV_LVL_LINK 3'h4
`define IRV_LVL_DISK1 3'h5
`define IRV_LVL_DISK0 3'h6
`define IRV_LVL_DMA 3'h7

`endif

// *** hdl/irv_pkg.sv ***
// Purpose: Types for the interrupt vector remapper
// Assumes: Nothing beyond the params header
// Notes: Nothing is imported elsewhere
package irv_pkg;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} irv_cpu_bus_t;

	typedef struct packed {
		logic panel;
		logic switch_n;
	} irv_nmi_src_t;

	typedef enum logic [1:0] {
		IRV_IDLE = 2'h1,
		IRV_HOLD = 2'h2
	} irv_state_t;

endpackage

// *** hdl/irv_sync3.sv ***
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Asynchronous inputs, one clock domain
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module irv_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : q_r[i];
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r <= '0;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
		end
	end

	assign q_o = q_r;
endmodule
`default_nettype wire

// *** tb/irv_remap_properties.sv ***
// Purpose: Port checks for irv_remap
// Assumes: Bound to irv_remap
// Notes: Remapped bus is one cycle late
`timescale 1ns/1ns
`default_nettype none
module irv_remap_properties (
	// Watched ports
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [7:0] irq_req_i,
	input wire logic [7:0] irq_mask_i,
	input wire irv_pkg::irv_nmi_src_t nmi_src_i,
	input wire logic boot_load_phase_i,
	input wire irv_pkg::irv_cpu_bus_t cpu_bus_i,
	input wire irv_pkg::irv_cpu_bus_t mem_bus_o,
	input wire logic irq_b_o,
	input wire logic nmi_b_o,
	input wire logic sys_reset_b_o,
	input wire logic [7:0] irq_level_lines_o,
	input wire logic nmi_source_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence fetch_hi;
		cpu_bus_i.valid && cpu_bus_i.addr == 16'hFFF8;
	endsequence
	sequence fetch_lo;
		cpu_bus_i.valid && cpu_bus_i.addr == 16'hFFF9;
	endsequence
	reset_pulse_a: assert property ($rose(rst_b_i) |-> !sys_reset_b_o [*8])
		else $error("reset short");
	rom_pair_a: assert property (fetch_hi ##0 !boot_load_phase_i |=>
		mem_bus_o.addr - 16'hFFE8 < 16'h10 && !mem_bus_o.addr[0]) else $error("rom pair");
	ram_pair_a: assert property (fetch_hi ##0 boot_load_phase_i |=>
		mem_bus_o.addr - 16'h01E8 < 16'h10 && !mem_bus_o.addr[0]) else $error("ram pair");
	pair_step_a: assert property (fetch_hi ##1 fetch_lo |=>
		mem_bus_o.addr == $past(mem_bus_o.addr) + 16'h1) else $error("pair step");
	pass_other_a: assert property (cpu_bus_i.valid && cpu_bus_i.addr[15:1] != 15'h7FFC |=>
		mem_bus_o == $past(cpu_bus_i)) else $error("pass");
	irq_line_a: assert property (1 |=>
		irq_b_o == !(|($past(irq_level_lines_o) & ~$past(irq_mask_i)))) else $error("irq");
	level_follow_a: assert property ($changed(irq_req_i) ##1 $stable(irq_req_i) [*8] |->
		irq_level_lines_o == irq_req_i) else $error("levels");
	nmi_panel_a: assert property (nmi_src_i.panel [*8] |-> !nmi_b_o && nmi_source_o)
		else $error("panel");
	nmi_switch_a: assert property ((!nmi_src_i.switch_n && !nmi_src_i.panel) [*8] |->
		!nmi_b_o && !nmi_source_o) else $error("switch");
endmodule
bind irv_remap irv_remap_properties chk (.*);
`default_nettype wire

// *** tb/irv_cpu_model.sv ***
// Purpose: Processor side of the address bus
// Assumes: Drives at the falling edge
// Notes: got holds the two remapped addresses
`timescale 1ns/1ns
`default_nettype none
module irv_cpu_model (
	// Inputs
	input wire logic clock_i,
	input wire irv_pkg::irv_cpu_bus_t mem_bus_i,
	input wire logic sys_reset_b_i,
	// Processor bus
	output irv_pkg::irv_cpu_bus_t cpu_bus_o
);
	logic [15:0] got [2];
	initial cpu_bus_o = '{1'b0, 16'h0};
	task automatic fetch(input logic [15:0] a);
		@(negedge clock_i);
		cpu_bus_o = '{1'b1, a};
		@(negedge clock_i);
		got[0] = mem_bus_i.addr;
		cpu_bus_o.addr = a + 16'h1;
		@(negedge clock_i);
		got[1] = mem_bus_i.addr;
		cpu_bus_o = '{1'b0, ~cpu_bus_o.addr};
	endtask
	// Start vector fetch on reset release
	always @(posedge sys_reset_b_i) fetch(16'hFFFE);
endmodule
`default_nettype wire

// *** tb/tb_irv_remap.sv ***
// Purpose: Self-checking bench for irv_remap
// Assumes: 50 MHz clock
// Notes: Inputs change at the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb_irv_remap;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] irq_req_i = 8'h00;
	logic [7:0] irq_mask_i = 8'h00;
	irv_pkg::irv_nmi_src_t nmi_src_i = '{1'b0, 1'b1};
	logic boot_load_phase_i = 1'b0;
	irv_pkg::irv_cpu_bus_t cpu_bus_i;
	irv_pkg::irv_cpu_bus_t mem_bus_o;
	logic irq_b_o, nmi_b_o, sys_reset_b_o, nmi_source_o;
	logic [7:0] irq_level_lines_o;
	int err_total = 0;
	int cmp_count = 0;
	always #10 clock_i = ~clock_i;
	irv_remap dut (.*);
	irv_cpu_model cpu (.clock_i(clock_i), .mem_bus_i(mem_bus_o), .sys_reset_b_i(sys_reset_b_o),
		.cpu_bus_o(cpu_bus_i));
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		$display("Compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic t_reset;
		int n = 0;
		repeat (20) @(negedge clock_i);
		cmp(16'({sys_reset_b_o, irq_b_o, nmi_b_o}), 16'h3);
		rst_b_i = 1'b1;
		while (sys_reset_b_o !== 1'b1 && n < 300) begin
			@(negedge clock_i);
			n++;
		end
		cmp(16'(n >= 100 && n < 300), 16'h1);
		repeat (4) @(negedge clock_i);
		cmp(cpu.got[0], 16'hFFFE);
	endtask
	task automatic t_levels;
		logic [15:0] e;
		for (int lv = 0; lv < 8; lv++) begin
			irq_req_i = 8'h01 << lv;
			repeat (8) @(negedge clock_i);
			cmp(16'(irq_level_lines_o), 16'(irq_req_i));
			cmp(16'(irq_b_o), 16'h0);
			boot_load_phase_i = lv[0];
			e = (lv[0] ? 16'h01E8 : 16'hFFE8) + 16'(2 * lv);
			cpu.fetch(16'hFFF8);
			cmp(cpu.got[0], e);
			cmp(cpu.got[1], e + 16'h1);
			irq_mask_i = irq_req_i;
			repeat (2) @(negedge clock_i);
			cmp(16'(irq_b_o), 16'h1);
			irq_mask_i = 8'h00;
		end
	endtask
	task automatic t_prio;
		@(negedge clock_i);
		irq_req_i = 8'h52;
		irq_mask_i = 8'h40;
		boot_load_phase_i = 1'b0;
		repeat (8) @(negedge clock_i);
		cpu.fetch(16'hFFF8);
		cmp(cpu.got[0], 16'hFFF0);
		cmp(cpu.got[1], 16'hFFF1);
		cpu.fetch(16'hFFF9);
		cmp(cpu.got[0], 16'hFFF1);
		cmp(cpu.got[1], 16'hFFFA);
		cpu.fetch(16'hFFF7);
		cmp(cpu.got[0], 16'hFFF7);
		cmp(cpu.got[1], 16'hFFF0);
		irq_req_i = 8'h00;
		irq_mask_i = 8'h00;
		cpu.fetch(16'hFFFA);
		cmp(cpu.got[0], 16'hFFFA);
		cmp(cpu.got[1], 16'hFFFB);
	endtask
	task automatic t_nmi;
		nmi_src_i.panel = 1'b1;
		repeat (8) @(negedge clock_i);
		cmp(16'({nmi_b_o, nmi_source_o}), 16'h1);
		cpu.fetch(16'hFFFC);
		cmp(cpu.got[1], 16'hFFFD);
		nmi_src_i = '{1'b0, 1'b0};
		repeat (8) @(negedge clock_i);
		cmp(16'({nmi_b_o, nmi_source_o}), 16'h0);
		nmi_src_i.switch_n = 1'b1;
		repeat (8) @(negedge clock_i);
		cmp(16'({nmi_b_o, nmi_source_o}), 16'h2);
	endtask
	initial begin
		t_reset();
		t_levels();
		t_prio();
		t_nmi();
		close_out();
	end
	initial begin
		#100000;
		err_total++;
		close_out();
	end
endmodule
`default_nettype wire
